// [verilog/rxsp_top.sv]
/*
 * Receive system-side TDM port for eight links: per-link data,
 * signaling, frame pulse and clock in master, slave or multiplexed
 * mode, with an APB register slave. Assumes the core presents each
 * link's next channel byte and nibble and advances on core_take_o.
 */
`timescale 1ns/1ns
module rxsp_top (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  // APB slave
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [7:0]       paddr_i,
  input  wire logic [31:0]      pwdata_i,
  output logic      [31:0]      prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  // Core side
  input  wire logic [7:0][7:0]  core_data_i,
  input  wire logic [7:0][3:0]  core_sig_i,
  input  wire logic [7:0]       core_gap_i,
  output logic      [7:0]       core_take_o,
  // Per-link system pins
  input  wire logic [7:0]       rx_sys_clk_i,
  output logic      [7:0]       rx_sys_clk_o,
  output logic      [7:0]       rx_sys_clk_oe_n_o,
  input  wire logic [7:0]       rx_frame_pulse_i,
  output logic      [7:0]       rx_frame_pulse_o,
  output logic      [7:0]       rx_frame_pulse_oe_n_o,
  output logic      [7:0]       rx_sys_data_o,
  output logic      [7:0]       rx_sig_out_o,
  // Multiplexed pins
  input  wire logic             mux_rx_sys_clk_i,
  input  wire logic             mux_rx_frame_pulse_i,
  output logic      [1:0]       mux_rx_data_primary_o,
  output logic      [1:0]       mux_rx_data_backup_o,
  output logic      [1:0]       mux_rx_sig_primary_o,
  output logic      [1:0]       mux_rx_sig_backup_o
);

  typedef struct packed {
    rxsp_pkg::rxsp_mode_t mode;
    logic                 e1;
    logic                 shared;
    logic [1:0]           fpsel;
    logic                 dbl;
    logic [7:0]           inv;
    logic [7:0]           seen;
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          prdata;
    logic [7:0]           ck1;
    logic [7:0]           ck2;
    logic [7:0]           ck3;
    logic [7:0]           fp1;
    logic [7:0]           fp2;
    logic [7:0]           half;
    logic [7:0]           mck;
    logic                 mc1;
    logic                 mc2;
    logic                 mc3;
    logic                 mf1;
    logic                 mf2;
    logic                 mhalf;
    logic [31:0]          acc;
    logic [4:0]           mcnt;
    logic [1:0]           sel;
    logic [7:0]           dat;
    logic [7:0]           sig;
    logic [7:0]           fpo;
    logic [7:0]           take;
    logic [1:0]           mdat;
    logic [1:0]           msig;
    logic                 oe_n;
  } rxsp_top_st_t;

  rxsp_top_st_t q;
  rxsp_top_st_t n;
  logic [7:0]   step;
  logic [7:0]   restart;
  logic [7:0]   edge_s;
  logic [32:0]  sum;
  logic         medge;
  logic         mstep;
  logic         mfp;
  logic [1:0]   slot;
  logic         acc_req;
  logic         commit;
  logic         is_master;
  logic [7:0]   lane_d;
  logic [7:0]   lane_s;
  logic [7:0]   lane_fp;
  logic [7:0]   lane_take;

  function automatic logic [31:0] ctrl_word(input rxsp_top_st_t st);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[rxsp_pkg::CTRL_MODE_LSB +: 2]  = st.mode;
    w[rxsp_pkg::CTRL_E1_BIT]         = st.e1;
    w[rxsp_pkg::CTRL_SHARED_BIT]     = st.shared;
    w[rxsp_pkg::CTRL_FPSEL_LSB +: 2] = st.fpsel;
    w[rxsp_pkg::CTRL_DBL_BIT]        = st.dbl;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    n         = q;
    step      = 8'h00;
    restart   = 8'h00;
    is_master = (q.mode != rxsp_pkg::RXSP_SLAVE) && (q.mode != rxsp_pkg::RXSP_MUX);
    // Clock pins pass three flops, frame pulses two; edge logic reads only the second and third
    n.ck1  = rx_sys_clk_i;
    n.ck2  = q.ck1;
    n.ck3  = q.ck2;
    n.fp1  = rx_frame_pulse_i;
    n.fp2  = q.fp1;
    n.mc1  = mux_rx_sys_clk_i;
    n.mc2  = q.mc1;
    n.mc3  = q.mc2;
    n.mf1  = mux_rx_frame_pulse_i;
    n.mf2  = q.mf1;
    edge_s = q.ck2 & ~q.ck3;
    medge  = q.mc2 && !q.mc3;
    // Fractional divider: jitter of one system clock is the trade-off
    sum    = {1'b0, q.acc} + {1'b0, (q.e1 ? rxsp_pkg::E1_INC : rxsp_pkg::T1_INC)};
    n.acc  = sum[31:0];
    // 16.384 MHz mux clock carries one bit every second edge
    mstep  = medge && (!q.dbl || q.mhalf);
    mfp    = q.mf2 ^ q.inv[0];
    slot   = mfp ? 2'h0 : q.mcnt[4:3];
    if (medge) begin
      n.mhalf = !q.mhalf;
    end

    for (int i = 0; i < 8; i++) begin
      if (is_master) begin
        if (sum[32] && !(core_gap_i[i] && !q.mck[i])) begin
          n.mck[i] = !q.mck[i];
          step[i]  = !q.mck[i];
        end
      end else if (q.mode == rxsp_pkg::RXSP_SLAVE) begin
        if (edge_s[q.shared ? 0 : i]) begin
          n.half[i] = !q.half[i];
          step[i]   = !q.dbl || q.half[i];
        end
        // sampled on active edge, polarity per link
        restart[i] = step[i] && (q.fp2[i] ^ q.inv[i]);
      end else begin
        step[i]    = mstep && (2'(i) == slot);
        restart[i] = mstep && mfp;
      end
    end
    if (mstep) begin
      n.mcnt = mfp ? 5'h01 : q.mcnt + 5'h01;
      n.sel  = slot;
    end

    // Pins
    n.dat  = lane_d;
    n.sig  = lane_s;
    n.take = lane_take;
    n.fpo  = lane_fp ^ q.inv;
    n.mdat = {lane_d[{1'b1, q.sel}], lane_d[{1'b0, q.sel}]};
    n.msig = {lane_s[{1'b1, q.sel}], lane_s[{1'b0, q.sel}]};

    // APB: pready one cycle into access, write at the sampling edge
    acc_req   = psel_i && penable_i && !q.pready;
    commit    = psel_i && penable_i && q.pready && pwrite_i;
    n.pready  = acc_req;
    n.pslverr = 1'b0;
    n.prdata  = 32'h0000_0000;
    if (acc_req) begin
      if (paddr_i == rxsp_pkg::CTRL_OFS) begin
        n.prdata = ctrl_word(q);
      end else if (paddr_i == rxsp_pkg::FPINV_OFS) begin
        n.prdata = {24'h00_0000, q.inv};
      end else if (paddr_i == rxsp_pkg::SEEN_OFS) begin
        n.prdata = {24'h00_0000, q.seen};
      end else begin
        n.pslverr = 1'b1;
      end
    end
    if (commit) begin
      if (paddr_i == rxsp_pkg::CTRL_OFS) begin
        n.mode   = rxsp_pkg::rxsp_mode_t'(pwdata_i[rxsp_pkg::CTRL_MODE_LSB +: 2]);
        n.e1     = pwdata_i[rxsp_pkg::CTRL_E1_BIT];
        n.shared = pwdata_i[rxsp_pkg::CTRL_SHARED_BIT];
        n.fpsel  = pwdata_i[rxsp_pkg::CTRL_FPSEL_LSB +: 2];
        n.dbl    = pwdata_i[rxsp_pkg::CTRL_DBL_BIT];
      end else if (paddr_i == rxsp_pkg::FPINV_OFS) begin
        n.inv = pwdata_i[7:0];
      end else if (paddr_i == rxsp_pkg::SEEN_OFS) begin
        n.seen = q.seen & ~pwdata_i[7:0];
      end
    end
    // Far side owns the clock and frame pulse pins outside master mode
    n.oe_n = (n.mode == rxsp_pkg::RXSP_SLAVE) || (n.mode == rxsp_pkg::RXSP_MUX);
    // New alignment beats a clear in the same cycle
    n.seen = n.seen | restart;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q        <= '0;
      q.mode   <= rxsp_pkg::rxsp_mode_t'(rxsp_pkg::CTRL_RST[rxsp_pkg::CTRL_MODE_LSB +: 2]);
      q.e1     <= rxsp_pkg::CTRL_RST[rxsp_pkg::CTRL_E1_BIT];
      q.shared <= rxsp_pkg::CTRL_RST[rxsp_pkg::CTRL_SHARED_BIT];
      q.fpsel  <= rxsp_pkg::CTRL_RST[rxsp_pkg::CTRL_FPSEL_LSB +: 2];
      q.dbl    <= rxsp_pkg::CTRL_RST[rxsp_pkg::CTRL_DBL_BIT];
      q.inv    <= rxsp_pkg::FPINV_RST;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  for (genvar g = 0; g < 8; g++) begin : g_lane
    rxsp_lane_if lif ();
    assign lif.step    = step[g];
    assign lif.restart = restart[g];
    assign lif.e1      = q.e1 || (q.mode == rxsp_pkg::RXSP_MUX);
    assign lif.fpsel   = q.fpsel;
    assign lif.cdata   = core_data_i[g];
    assign lif.csig    = core_sig_i[g];
    assign lane_d[g]    = lif.d;
    assign lane_s[g]    = lif.s;
    assign lane_fp[g]   = lif.fp;
    assign lane_take[g] = lif.take;
    rxsp_lane u_lane (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .lane_io   (lif.lane)
    );
  end

  assign prdata_o              = q.prdata;
  assign pready_o              = q.pready;
  assign pslverr_o             = q.pslverr;
  assign core_take_o           = q.take;
  assign rx_sys_clk_o          = q.mck;
  assign rx_sys_clk_oe_n_o     = {8{q.oe_n}};
  assign rx_frame_pulse_o      = q.fpo;
  assign rx_frame_pulse_oe_n_o = {8{q.oe_n}};
  assign rx_sys_data_o         = q.dat;
  assign rx_sig_out_o          = q.sig;
  assign mux_rx_data_primary_o = q.mdat;
  assign mux_rx_data_backup_o  = q.mdat;
  assign mux_rx_sig_primary_o  = q.msig;
  assign mux_rx_sig_backup_o   = q.msig;

  ////////////////////////////////////////////////////////////////////
  backup_sig_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    mux_rx_sig_backup_o == mux_rx_sig_primary_o)
    else $error("backup signaling differs from primary");

  gap_hold_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (is_master && core_gap_i[0] && !rx_sys_clk_o[0]) |=> !rx_sys_clk_o[0])
    else $error("master clock edge during gap");

  data_edge_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    ($changed(rx_sys_data_o[0]) && $past(is_master, 3) && $past(is_master, 2))
    |-> ($past(rx_sys_clk_o[0], 1) && !$past(rx_sys_clk_o[0], 2)))
    else $error("data changed away from clock edge");

  sig_edge_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    ($changed(rx_sig_out_o[1]) && $past(is_master, 3) && $past(is_master, 2))
    |-> ($past(rx_sys_clk_o[1], 1) && !$past(rx_sys_clk_o[1], 2)))
    else $error("signaling changed away from clock edge");

  shared_clk_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (q.mode == rxsp_pkg::RXSP_SLAVE && q.shared && step[5]) |-> edge_s[0])
    else $error("shared clock not from link one");

  own_clk_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (q.mode == rxsp_pkg::RXSP_SLAVE && !q.shared && step[5]) |-> edge_s[5])
    else $error("link stepped by foreign clock");

  mux_slot_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (q.mode == rxsp_pkg::RXSP_MUX && (step[2] || step[6]))
    |-> (step[2] && step[6] && slot == 2'h2 && step[1:0] == 2'h0))
    else $error("mux slot carries wrong links");

  fp_pol_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (q.mode == rxsp_pkg::RXSP_SLAVE && restart[3]) |-> (step[3] && (q.fp2[3] != q.inv[3])))
    else $error("frame pulse sampled with wrong polarity");

endmodule

// [verilog/rxsp_pkg.sv]
/*
 * Constants for the receive system-side TDM port: register map,
 * control fields, reset values, frame geometry and clock rates.
 * Assumes a 250 MHz system clock.
 */
package rxsp_pkg;

  typedef enum logic [1:0] {
    RXSP_MASTER,
    RXSP_SLAVE,
    RXSP_MUX
  } rxsp_mode_t;

  // Register offsets
  localparam logic [7:0]  CTRL_OFS        = 8'h00;
  localparam logic [7:0]  FPINV_OFS       = 8'h04;
  localparam logic [7:0]  SEEN_OFS        = 8'h08;

  // Control fields
  localparam int          CTRL_MODE_LSB   = 0;
  localparam int          CTRL_E1_BIT     = 2;
  localparam int          CTRL_SHARED_BIT = 3;
  localparam int          CTRL_FPSEL_LSB  = 4;
  localparam int          CTRL_DBL_BIT    = 6;

  // Reset values
  localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
  localparam logic [7:0]  FPINV_RST       = 8'h00;

  // E1 frame pulse choices
  localparam logic [1:0]  FPSEL_BASIC     = 2'h0;
  localparam logic [1:0]  FPSEL_CRC_MF    = 2'h1;
  localparam logic [1:0]  FPSEL_SIG_MF    = 2'h2;
  localparam logic [1:0]  FPSEL_TS_OH     = 2'h3;
  localparam logic [4:0]  TS_ONE          = 5'h01;
  localparam logic [4:0]  TS_SIXTEEN      = 5'h10;

  // Frame geometry
  localparam logic [7:0]  T1_LAST_BIT     = 8'hC0;
  localparam logic [7:0]  E1_LAST_BIT     = 8'hFF;
  localparam logic [4:0]  T1_LAST_FRAME   = 5'h17;
  localparam logic [4:0]  E1_LAST_FRAME   = 5'h0F;

  // Master clock synthesis
  localparam longint      SYS_HZ          = 250000000;
  localparam longint      T1_HZ           = 1544000;
  localparam longint      E1_HZ           = 2048000;
  localparam logic [31:0] T1_INC = 32'((2 * T1_HZ * (longint'(1) << 32)) / SYS_HZ);
  localparam logic [31:0] E1_INC = 32'((2 * E1_HZ * (longint'(1) << 32)) / SYS_HZ);

endpackage

// [verilog/rxsp_lane_if.sv]
/*
 * Per-link carrier between the port controller and one lane.
 * Assumes both ends run on the system clock.
 */
`timescale 1ns/1ns
interface rxsp_lane_if;
  logic       step;
  logic       restart;
  logic       e1;
  logic [1:0] fpsel;
  logic [7:0] cdata;
  logic [3:0] csig;
  logic       d;
  logic       s;
  logic       fp;
  logic       take;

  modport lane (input step, restart, e1, fpsel, cdata, csig,
                output d, s, fp, take);
  modport ctrl (output step, restart, e1, fpsel, cdata, csig,
                input d, s, fp, take);
endinterface

// [verilog/rxsp_lane.sv]
/*
 * One link lane: frame position, channel serialiser for data and
 * signaling, master frame pulse. Assumes step and restart are
 * one-cycle strobes from the controller on the system clock.
 */
`timescale 1ns/1ns
module rxsp_lane (
  // Clock and reset
  input wire logic  sys_clk_i,
  input wire logic  rst_i,
  // Controller side
  rxsp_lane_if.lane lane_io
);

  typedef struct packed {
    logic [7:0] cnt;
    logic [4:0] frm;
    logic [7:0] dsh;
    logic [7:0] ssh;
    logic       d;
    logic       s;
    logic       fp;
    logic       take;
  } rxsp_lane_st_t;

  rxsp_lane_st_t q;
  rxsp_lane_st_t n;
  logic [7:0]    pos;
  logic [4:0]    fr;
  logic          load;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    n    = q;
    pos  = lane_io.restart ? 8'h00 : q.cnt;
    fr   = lane_io.restart ? 5'h00 : q.frm;
    // T1 bit 0 is the framing bit, channels follow it
    load = lane_io.e1 ? (pos[2:0] == 3'h0) : (pos != 8'h00 && pos[2:0] == 3'h1);
    n.take = 1'b0;
    if (lane_io.restart) begin
      n.cnt = 8'h00;
      n.frm = 5'h00;
    end
    if (lane_io.step) begin
      n.take = load;
      if (load) begin
        n.d   = lane_io.cdata[7];
        n.dsh = {lane_io.cdata[6:0], 1'b0};
        n.s   = 1'b0;
        n.ssh = {3'h0, lane_io.csig, 1'b0};
      end else if (!lane_io.e1 && pos == 8'h00) begin
        n.d = 1'b0;
        n.s = 1'b0;
      end else begin
        n.d   = q.dsh[7];
        n.dsh = {q.dsh[6:0], 1'b0};
        n.s   = q.ssh[7];
        n.ssh = {q.ssh[6:0], 1'b0};
      end
      if (!lane_io.e1) begin
        n.fp = (pos == 8'h00) && (fr == 5'h00);
      end else begin
        case (lane_io.fpsel)
          rxsp_pkg::FPSEL_BASIC: n.fp = (pos == 8'h00);
          rxsp_pkg::FPSEL_TS_OH: n.fp = (pos[7:3] == rxsp_pkg::TS_ONE)
                                     || (pos[7:3] == rxsp_pkg::TS_SIXTEEN);
          default:               n.fp = (pos == 8'h00) && (fr == 5'h00);
        endcase
      end
      if (pos == (lane_io.e1 ? rxsp_pkg::E1_LAST_BIT : rxsp_pkg::T1_LAST_BIT)) begin
        n.cnt = 8'h00;
        if (fr == (lane_io.e1 ? rxsp_pkg::E1_LAST_FRAME : rxsp_pkg::T1_LAST_FRAME)) begin
          n.frm = 5'h00;
        end else begin
          n.frm = fr + 5'h01;
        end
      end else begin
        n.cnt = pos + 8'h01;
        n.frm = fr;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign lane_io.d    = q.d;
  assign lane_io.s    = q.s;
  assign lane_io.fp   = q.fp;
  assign lane_io.take = q.take;

  ////////////////////////////////////////////////////////////////////
  sig_nibble_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (lane_io.step && load) |=> (!q.s && q.take && q.ssh[7:5] == 3'h0))
    else $error("signaling not in lower nibble");

  t1_fp_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (lane_io.step && !lane_io.e1 && !lane_io.restart && (q.cnt != 8'h00 || q.frm != 5'h00))
    |=> !q.fp)
    else $error("T1 frame pulse outside multiframe start");

endmodule

// [verif/rxsp_far_model.sv]
/*
 Far-side system logic: link clocks, mux clock and mux frame pulse.
 Assumes the bench resolves the shared pins from the device enables.
*/
`timescale 1ns/1ns
module rxsp_far_model (
  // Bench controls
  input  wire logic [7:0] clk_en_i,
  input  wire logic       mux_en_i,
  input  wire logic       fp_inv_i,
  input  wire logic       frame_go_i,
  // Driven pins
  output logic      [7:0] clk_o,
  output logic      [7:0] fp_o,
  output logic            mux_clk_o,
  output logic            mux_fp_o
);
  logic lclk;
  logic mclk;
  logic fp_act;
  //////////////////////////////////////////////////
  // link clock, paired with double rate
  initial begin
    lclk = 1'b0;
    forever begin
      #62 lclk = ~lclk;
      #63 lclk = ~lclk;
    end
  end
  initial begin
    mclk = 1'b0;
    forever #61 mclk = ~mclk;
  end
  // Released clocks sit at the pull-up level
  assign clk_o     = ~clk_en_i | {8{lclk}};
  assign mux_clk_o = ~mux_en_i | mclk;
  //////////////////////////////////////////////////
  // one frame start across a sampling edge
  initial begin
    fp_act = 1'b0;
    forever begin
      @(posedge frame_go_i);
      @(negedge mux_clk_o);
      fp_act = 1'b1;
      @(negedge mux_clk_o);
      fp_act = 1'b0;
    end
  end
  assign mux_fp_o = fp_act ^ fp_inv_i;
  assign fp_o     = {8{fp_inv_i}};
endmodule

// [verif/rxsp_top_tb.sv]
/*
 Bench for the receive system-side port: APB tasks, fixed core feed,
 far-side model and sequenced tests. Assumes APB answers within 50 cycles.
*/
`timescale 1ns/1ns
module rxsp_top_tb;
  logic            sys_clk_i;
  logic            rst_i;
  logic            psel_i, penable_i, pwrite_i;
  logic [7:0]      paddr_i;
  logic [31:0]     pwdata_i, prdata_o;
  logic            pready_o, pslverr_o;
  logic [7:0][7:0] core_data_i;
  logic [7:0][3:0] core_sig_i;
  logic [7:0]      core_gap_i, core_take_o;
  logic [7:0]      rx_sys_clk_i, rx_sys_clk_o, rx_sys_clk_oe_n_o;
  logic [7:0]      rx_frame_pulse_i, rx_frame_pulse_o, rx_frame_pulse_oe_n_o;
  logic [7:0]      rx_sys_data_o, rx_sig_out_o;
  logic            mux_rx_sys_clk_i, mux_rx_frame_pulse_i;
  logic [1:0]      mux_rx_data_primary_o, mux_rx_data_backup_o;
  logic [1:0]      mux_rx_sig_primary_o, mux_rx_sig_backup_o;
  logic [7:0]      p_clk, p_fp, p_en;
  logic            p_mux_en, p_inv, p_go;
  int              n_fail, cmp_count;

  // Shared pins: the device wins while its enable is low
  assign rx_sys_clk_i = (~rx_sys_clk_oe_n_o & rx_sys_clk_o) | (rx_sys_clk_oe_n_o & p_clk);
  assign rx_frame_pulse_i = (~rx_frame_pulse_oe_n_o & rx_frame_pulse_o)
                          | (rx_frame_pulse_oe_n_o & p_fp);

  rxsp_top u_dut (.sys_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .core_data_i, .core_sig_i, .core_gap_i, .core_take_o,
    .rx_sys_clk_i, .rx_sys_clk_o, .rx_sys_clk_oe_n_o, .rx_frame_pulse_i, .rx_frame_pulse_o,
    .rx_frame_pulse_oe_n_o, .rx_sys_data_o, .rx_sig_out_o, .mux_rx_sys_clk_i,
    .mux_rx_frame_pulse_i, .mux_rx_data_primary_o, .mux_rx_data_backup_o,
    .mux_rx_sig_primary_o, .mux_rx_sig_backup_o);
  rxsp_far_model u_far (.clk_en_i(p_en), .mux_en_i(p_mux_en), .fp_inv_i(p_inv),
    .frame_go_i(p_go), .clk_o(p_clk), .fp_o(p_fp), .mux_clk_o(mux_rx_sys_clk_i),
    .mux_fp_o(mux_rx_frame_pulse_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  //////////////////////////////////////////////////
  function automatic logic [7:0] byte_of(input int n);
    return 8'(8'hC3 + 8'h11 * n);
  endfunction
  function automatic logic [3:0] nib_of(input int n);
    return 4'(4'h9 ^ n);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    @(posedge sys_clk_i);
    while (pready_o !== 1'b1) begin
      n++;
      @(posedge sys_clk_i);
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
    check(32'(n < 50), 32'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, x);
    check({31'h0, e}, {31'h0, xe});
  endtask
  // One byte from the take pulse on, sampled after each active edge settles
  task automatic cap(input int ln, output logic [7:0] d, output logic [7:0] s);
    int n;
    n = 0;
    while (core_take_o[ln] !== 1'b1 && n < 3000) begin
      n++;
      @(posedge sys_clk_i);
    end
    check(32'(n < 3000), 32'h1);
    d[7] = rx_sys_data_o[ln];
    s[7] = rx_sig_out_o[ln];
    for (int b = 6; b >= 0; b--) begin
      @(posedge rx_sys_clk_o[ln]);
      repeat (3) @(posedge sys_clk_i);
      d[b] = rx_sys_data_o[ln];
      s[b] = rx_sig_out_o[ln];
    end
  endtask
  task automatic takes(input int ln, output int c);
    c = 0;
    repeat (4000) begin
      @(posedge sys_clk_i);
      if (core_take_o[ln] === 1'b1) c++;
    end
  endtask
  task automatic period(output int p);
    time t;
    @(posedge rx_sys_clk_o[0]);
    t = $time;
    @(posedge rx_sys_clk_o[0]);
    p = int'(($time - t) / 4);
    @(posedge sys_clk_i);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////
  // Generous against the longest frame-pulse search
  initial begin
    #400000;
    n_fail++;
    finish_test();
  end

  initial begin
    logic [7:0]  d, s;
    logic [15:0] d0, d1, s0, s1;
    int          p, c, c7, bad;
    n_fail = 0;
    cmp_count = 0;
    rst_i = 1'b1;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {core_gap_i, p_en, p_mux_en, p_inv, p_go} = '0;
    for (int n = 0; n < 8; n++) begin
      core_data_i[n] = byte_of(n);
      core_sig_i[n] = nib_of(n);
    end
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    rd_chk(rxsp_pkg::CTRL_OFS, rxsp_pkg::CTRL_RST, 1'b0);
    rd_chk(rxsp_pkg::FPINV_OFS, 32'(rxsp_pkg::FPINV_RST), 1'b0);
    rd_chk(8'h0C, 32'h0, 1'b1);
    check({16'h0, rx_sys_clk_oe_n_o, rx_frame_pulse_oe_n_o}, 32'h0);
    wr(rxsp_pkg::CTRL_OFS, 32'h0000_0004);
    rd_chk(rxsp_pkg::CTRL_OFS, 32'h0000_0004, 1'b0);
    for (int n = 0; n < 8; n += 7) begin
      cap(n, d, s);
      check({24'h0, d}, {24'h0, byte_of(n)});
      check({24'h0, s}, {28'h0, nib_of(n)});
    end
    period(p);
    check(32'(p >= 121 && p <= 124), 32'h1);
    wr(rxsp_pkg::CTRL_OFS, 32'h0);
    period(p);
    period(p);
    check(32'(p >= 160 && p <= 163), 32'h1);
    core_gap_i <= 8'h01;
    repeat (200) @(posedge sys_clk_i);
    d[0] = rx_sys_data_o[0];
    bad = 0;
    repeat (300) begin
      @(posedge sys_clk_i);
      if (rx_sys_clk_o[0] !== 1'b0 || rx_sys_data_o[0] !== d[0]) bad++;
    end
    check(bad, 0);
    core_gap_i <= 8'h00;
    wr(rxsp_pkg::CTRL_OFS, 32'h0000_0034);
    wr(rxsp_pkg::FPINV_OFS, 32'h0000_0001);
    c = 0;
    while (rx_frame_pulse_o[0] !== 1'b1 && c < 40000) begin
      c++;
      @(posedge sys_clk_i);
    end
    while (rx_frame_pulse_o[0] !== 1'b0 && c < 40000) begin
      c++;
      @(posedge sys_clk_i);
    end
    check(32'(c < 40000), 32'h1);
    c = 0;
    repeat (20) begin
      @(posedge rx_sys_clk_o[0]);
      repeat (3) @(posedge sys_clk_i);
      if (rx_frame_pulse_o[0] === 1'b0) c++;
    end
    check(c, 7);
    wr(rxsp_pkg::FPINV_OFS, 32'h0);
    p_en <= 8'h01;
    wr(rxsp_pkg::CTRL_OFS, 32'h0000_004D);
    check({16'h0, rx_sys_clk_oe_n_o, rx_frame_pulse_oe_n_o}, 32'h0000_FFFF);
    takes(7, c7);
    check(32'(c7 > 0), 32'h1);
    wr(rxsp_pkg::CTRL_OFS, 32'h0000_0045);
    repeat (50) @(posedge sys_clk_i);
    takes(7, c7);
    takes(0, c);
    check({31'h0, c7 == 0 && c > 0}, 32'h1);
    p_en <= 8'h00;
    p_mux_en <= 1'b1;
    p_inv <= 1'b1;
    wr(rxsp_pkg::FPINV_OFS, 32'h1);
    wr(rxsp_pkg::CTRL_OFS, 32'h2);
    p_go <= 1'b1;
    c = 0;
    while (mux_rx_frame_pulse_i !== 1'b0 && c < 1000) begin
      c++;
      @(posedge sys_clk_i);
    end
    check(32'(c < 1000), 32'h1);
    bad = 0;
    for (int b = 15; b >= 0; b--) begin
      @(posedge mux_rx_sys_clk_i);
      repeat (15) @(posedge sys_clk_i);
      {d1[b], d0[b]} = mux_rx_data_primary_o;
      {s1[b], s0[b]} = mux_rx_sig_primary_o;
      if ({mux_rx_data_backup_o, mux_rx_sig_backup_o}
          !== {mux_rx_data_primary_o, mux_rx_sig_primary_o}) bad++;
    end
    check({d0, d1}, {byte_of(0), byte_of(1), byte_of(4), byte_of(5)});
    check({s0, s1}, {4'h0, nib_of(0), 4'h0, nib_of(1), 4'h0, nib_of(4), 4'h0, nib_of(5)});
    check(bad, 0);
    // Mux frame pulse realigned every lane once
    rd_chk(rxsp_pkg::SEEN_OFS, 32'h0000_00FF, 1'b0);
    wr(rxsp_pkg::SEEN_OFS, 32'h0000_00FF);
    rd_chk(rxsp_pkg::SEEN_OFS, 32'h0000_0000, 1'b0);
    finish_test();
  end
endmodule
